// [design/lccc_pkg.sv]
/*
  package for the logic cell carry/counter array: register offsets,
  control field layout, reset values and array geometry.
  assumes a 32-bit Avalon-MM slave with byte addresses on aligned words.
*/
package lccc_pkg;

  // ------------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------------
  localparam int CELLS_PER_GRP = 10;
  localparam int NUM_GRP       = 3;
  localparam int NUM_CELLS     = CELLS_PER_GRP * NUM_GRP;
  localparam int EMU_EXTRA     = 3;
  localparam logic [4:0] MAX_WIDTH = 5'h1D;
  localparam logic [4:0] MIN_WIDTH = 5'h01;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OPA     = 8'h04;
  localparam logic [7:0] OFF_OPB     = 8'h08;
  localparam logic [7:0] OFF_LOADVAL = 8'h0C;
  localparam logic [7:0] OFF_TABLE   = 8'h10;
  localparam logic [7:0] OFF_REGVAL  = 8'h14;
  localparam logic [7:0] OFF_OUT0    = 8'h18;
  localparam logic [7:0] OFF_OUT1    = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_BITS   = 21;
  localparam int ST_CARRY    = 0;
  localparam int ST_CASCADE  = 1;
  localparam int ST_UNDEF    = 2;
  localparam int ST_RSTSEEN  = 3;
  localparam int ST_USED_LSB = 8;
  localparam logic [CTRL_BITS-1:0] CTRL_RST = 21'h080020;

  typedef enum logic [1:0] {
    MODE_ARITH = 2'h0,
    MODE_COUNT = 2'h1,
    MODE_CMP   = 2'h2
  } lccc_mode_t;

  // control word, bit 0 is mode[0]
  typedef struct packed {
    logic [4:0] width;
    logic [2:0] grpClr;
    logic       sload;
    logic       sclr;
    logic       run;
    logic       cascUse;
    logic       simulEmu;
    logic       presetEmu;
    logic       carryIn0;
    logic       devRstEn;
    logic       out1Reg;
    logic       out0Reg;
    logic       regUse;
    lccc_mode_t mode;
  } lccc_ctrl_t;

endpackage

// [design/lccc_cell_array.sv]
/*
  thirty logic cells in three groups of ten, chained by a carry path and
  a cascade path, each cell with a table, one register and two outputs.
  assumes clk at 250 MHz, Avalon-MM master on the register side and a
  low-active device-wide reset pin that may arrive at any time.
*/
// Design decisions made here: the Avalon-MM slave port and the register offsets.
// Functional notes
// - carry in feeds table and next stage
// - chain cells one to ten, across groups
// - long chains hop to same-parity group; positions 20-29 go from group 2 back to group 1
// - n-bit adder uses n+1 cells, sum out
// - register bypassed or holding the sum
// - carry to next bit; last cell routes
// - counter uses data table and carry table
// - counter has sync load and sync clear
// - clear or load beats cascade value
// - clear wins over load together
// - two outputs, each table or register
// - arithmetic cell shows both forms together
// - group-wide clear, native async clear only
// - emulated preset-clear costs three cells
// - emulated preset-load undefined after reset
// - device reset clears all, highest priority
// - emulated preset register reads preset
// - cascade builds wide compare between cells
`timescale 1ns/1ns
`default_nettype none

module lccc_cell_array (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        deviceWideResetN,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [29:0] cellOut0,
  output logic      [29:0] cellOut1,
  output logic             carryOutRouted,
  output logic             cascadeOut
);

  localparam int N = lccc_pkg::NUM_CELLS;

  // ------------------------------------------------------------------
  // software-visible state
  // ------------------------------------------------------------------
  lccc_pkg::lccc_ctrl_t ctrl;
  logic [N-1:0]         opA;
  logic [N-1:0]         opB;
  logic [N-1:0]         loadVal;
  logic                 undefFlag;
  logic                 rstSeen;

  // ------------------------------------------------------------------
  // cell array nets
  // ------------------------------------------------------------------
  logic [N:0]           carry;
  logic [N:0]           casc;
  logic [N-1:0]         tab;
  logic [N-1:0]         stored;
  logic [N-1:0]         regVis;
  logic [N-1:0]         out0;
  logic [N-1:0]         out1;
  logic [N-1:0]         inUse;
  logic [N-1:0]         cellArst;
  logic [4:0]           nEff;
  logic [5:0]           cellsUsed;
  logic                 devRst;
  logic                 busHit;
  logic                 wrStrobe;
  logic [31:0]          next_readdata;

  // device reset only counts when software has armed it
  assign devRst = ctrl.devRstEn & ~deviceWideResetN;

  // clamp the adder width so n+1 cells always fit the cluster
  always_comb begin
    if (ctrl.width > lccc_pkg::MAX_WIDTH) begin
      nEff = lccc_pkg::MAX_WIDTH;
    end else if (ctrl.width < lccc_pkg::MIN_WIDTH) begin
      nEff = lccc_pkg::MIN_WIDTH;
    end else begin
      nEff = ctrl.width;
    end
  end

  // cells taken: n bits, one carry-out cell, plus emulation overhead
  always_comb begin
    cellsUsed = 6'({1'b0, nEff} + 6'h01);
    if (ctrl.simulEmu) begin
      cellsUsed = 6'(cellsUsed + 6'(lccc_pkg::EMU_EXTRA));
    end
  end

  // chain position to group: positions 0-9 in group 0, 10-19 hop
  // to group 2, 20-29 fall back to group 1 so only the first hop keeps parity
  function automatic int grpOf(input int pos);
    int g;
    g = pos / lccc_pkg::CELLS_PER_GRP;
    if (g == 0) begin
      return 0;
    end else if (g == 1) begin
      return 2;
    end else begin
      return 1;
    end
  endfunction

  // chain entry; carry is driven by processes only, never mixed with assign
  always_comb begin
    carry[0] = ctrl.carryIn0;
  end
  assign casc[0]  = 1'b1;

  // ------------------------------------------------------------------
  // per-cell logic, one generate loop over the chain
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : gCell
    logic opBitA;
    logic opBitB;
    logic dataBit;
    logic nextBit;
    logic isLast;

    assign inUse[i]  = (5'(i) < nEff);
    assign isLast    = (5'(i) == nEff);
    // group clear is shared by all ten cells of a group
    assign cellArst[i] = devRst | ctrl.grpClr[grpOf(i)];

    // the register is held inverted when a preset is emulated
    assign regVis[i] = stored[i] ^ ctrl.presetEmu;

    // accumulator folds the register back in as operand a
    assign opBitA = (ctrl.regUse && ctrl.mode == lccc_pkg::MODE_ARITH)
                    ? regVis[i] : opA[i];
    assign opBitB = opB[i];

    // table and carry table per mode
    always_comb begin
      tab[i]       = 1'b0;
      carry[i + 1] = 1'b0;
      if (inUse[i]) begin
        unique case (ctrl.mode)
          lccc_pkg::MODE_ARITH: begin
            tab[i]       = opBitA ^ opBitB ^ carry[i];
            carry[i + 1] = (opBitA & opBitB) | (opBitA & carry[i])
                           | (opBitB & carry[i]);
          end
          lccc_pkg::MODE_COUNT: begin
            tab[i]       = regVis[i] ^ carry[i];
            carry[i + 1] = regVis[i] & carry[i];
          end
          lccc_pkg::MODE_CMP: begin
            tab[i]       = ~(opBitA ^ opBitB);
            carry[i + 1] = 1'b0;
          end
          default: begin
            tab[i]       = 1'b0;
            carry[i + 1] = 1'b0;
          end
        endcase
      end else if (isLast) begin
        // spare cell that lifts the final carry onto routing
        tab[i] = carry[i];
      end
    end

    // cascade ANDs table outputs of in-use cells, no local routing
    assign casc[i + 1] = casc[i] & (tab[i] | ~inUse[i]);

    // counter data may be gated by the cascade; clear and load win
    assign dataBit = (ctrl.mode == lccc_pkg::MODE_COUNT && ctrl.cascUse)
                     ? (tab[i] & casc[i]) : tab[i];

    always_comb begin
      nextBit = regVis[i];
      if (ctrl.mode == lccc_pkg::MODE_COUNT) begin
        if (ctrl.sclr) begin
          nextBit = 1'b0;
        end else if (ctrl.sload) begin
          nextBit = loadVal[i];
        end else begin
          nextBit = dataBit;
        end
      end else if (ctrl.regUse) begin
        nextBit = tab[i];
      end
    end

    // native asynchronous clear; preset comes from the inversion
    always_ff @(posedge clk or posedge cellArst[i]) begin
      if (cellArst[i]) begin
        stored[i] <= 1'b0;
      end else if (ctrl.run && inUse[i]) begin
        stored[i] <= nextBit ^ ctrl.presetEmu;
      end
    end

    // each output picks table or register on its own
    assign out0[i] = ctrl.out0Reg ? regVis[i] : tab[i];
    assign out1[i] = ctrl.out1Reg ? regVis[i] : tab[i];
  end

  // ------------------------------------------------------------------
  // registered pin outputs
  // ------------------------------------------------------------------
  // one flop stage keeps the pins glitch free at the cost of a cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cellOut0       <= 30'h00000000;
      cellOut1       <= 30'h00000000;
      carryOutRouted <= 1'b0;
      cascadeOut     <= 1'b0;
    end else begin
      cellOut0       <= out0;
      cellOut1       <= out1;
      carryOutRouted <= tab[nEff];
      cascadeOut     <= casc[N];
    end
  end

  // ------------------------------------------------------------------
  // emulation and reset status flags
  // ------------------------------------------------------------------
  // a preset-and-load emulation has no known value after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      undefFlag <= 1'b0;
    end else if (devRst && ctrl.simulEmu) begin
      undefFlag <= 1'b1;
    end else if (ctrl.run && ctrl.sload && !ctrl.sclr
                 && ctrl.mode == lccc_pkg::MODE_COUNT) begin
      undefFlag <= 1'b0;
    end
  end

  // sticky reset marker; a new reset beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstSeen <= 1'b0;
    end else if (devRst) begin
      rstSeen <= 1'b1;
    end else if (wrStrobe && avs_address == lccc_pkg::OFF_STATUS
                 && avs_writedata[lccc_pkg::ST_RSTSEEN]) begin
      rstSeen <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------
  // every access waits exactly one cycle; the request is taken on
  // the edge where waitrequest is seen low
  assign busHit   = (avs_read | avs_write) & avs_waitrequest;
  assign wrStrobe = avs_write & ~avs_waitrequest;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if (busHit) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // control and operand writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl    <= lccc_pkg::lccc_ctrl_t'(lccc_pkg::CTRL_RST);
      opA     <= 30'h00000000;
      opB     <= 30'h00000000;
      loadVal <= 30'h00000000;
    end else if (wrStrobe) begin
      unique case (avs_address)
        lccc_pkg::OFF_CTRL: begin
          ctrl <= lccc_pkg::lccc_ctrl_t'(avs_writedata[lccc_pkg::CTRL_BITS-1:0]);
        end
        lccc_pkg::OFF_OPA: begin
          opA <= avs_writedata[N-1:0];
        end
        lccc_pkg::OFF_OPB: begin
          opB <= avs_writedata[N-1:0];
        end
        lccc_pkg::OFF_LOADVAL: begin
          loadVal <= avs_writedata[N-1:0];
        end
        default: begin
          // read-only or unmapped: dropped here; a status write clears rstSeen above
        end
      endcase
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    next_readdata = 32'h00000000;
    unique case (avs_address)
      lccc_pkg::OFF_CTRL: begin
        next_readdata[lccc_pkg::CTRL_BITS-1:0] = ctrl;
      end
      lccc_pkg::OFF_OPA: begin
        next_readdata[N-1:0] = opA;
      end
      lccc_pkg::OFF_OPB: begin
        next_readdata[N-1:0] = opB;
      end
      lccc_pkg::OFF_LOADVAL: begin
        next_readdata[N-1:0] = loadVal;
      end
      lccc_pkg::OFF_TABLE: begin
        next_readdata[N-1:0] = tab;
      end
      lccc_pkg::OFF_REGVAL: begin
        next_readdata[N-1:0] = regVis;
      end
      lccc_pkg::OFF_OUT0: begin
        next_readdata[N-1:0] = out0;
      end
      lccc_pkg::OFF_OUT1: begin
        next_readdata[N-1:0] = out1;
      end
      lccc_pkg::OFF_STATUS: begin
        next_readdata[lccc_pkg::ST_CARRY]   = tab[nEff];
        next_readdata[lccc_pkg::ST_CASCADE] = casc[N];
        next_readdata[lccc_pkg::ST_UNDEF]   = undefFlag;
        next_readdata[lccc_pkg::ST_RSTSEEN] = rstSeen;
        next_readdata[lccc_pkg::ST_USED_LSB +: 6] = cellsUsed;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  // read data captured with the answer, held until the next one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (busHit && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule

`default_nettype wire

// [verif/lccc_array_chk.sv]
/*
  checker on the cell array ports: bus handshake, quiet pins, device reset.
  assumes it is bound to lccc_cell_array and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module lccc_array_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        deviceWideResetN,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [29:0] cellOut0,
  input wire logic [29:0] cellOut1,
  input wire logic        carryOutRouted,
  input wire logic        cascadeOut
);
  // ------
  // shadow of software state
  // ------
  lccc_pkg::lccc_ctrl_t ctl;
  logic [31:0]          opA;
  logic [31:0]          opB;
  logic [31:0]          msk;
  logic [32:0]          sum;
  logic [2:0]           quiet;
  logic                 wrDone;
  assign wrDone = avs_write && !avs_waitrequest;
  assign msk    = (32'h1 << ctl.width) - 32'h1;
  assign sum    = {1'h0, opA & msk} + {1'h0, opB & msk} + {32'h0, ctl.carryIn0};
  // quiet counts edges since anything could move the pins; saturates at 4
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl   <= lccc_pkg::lccc_ctrl_t'(lccc_pkg::CTRL_RST);
      opA   <= 32'h0;
      opB   <= 32'h0;
      quiet <= 3'h0;
    end else begin
      if (wrDone && avs_address == lccc_pkg::OFF_CTRL) begin
        ctl <= lccc_pkg::lccc_ctrl_t'(avs_writedata[lccc_pkg::CTRL_BITS-1:0]);
      end
      if (wrDone && avs_address == lccc_pkg::OFF_OPA) begin
        opA <= avs_writedata;
      end
      if (wrDone && avs_address == lccc_pkg::OFF_OPB) begin
        opB <= avs_writedata;
      end
      if (wrDone || (!deviceWideResetN && ctl.devRstEn)) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h4) begin
        quiet <= quiet + 3'h1;
      end
    end
  end
  // ------
  // properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  answer_due_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("access not answered next cycle");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  no_ack_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read");
  pins_quiet_a:
    assert property (quiet == 3'h4 && !ctl.run |-> $stable({cellOut0, cellOut1, carryOutRouted}))
    else $error("pins moved while idle");
  carry_out_a:
    assert property (ctl.mode == lccc_pkg::MODE_ARITH && !ctl.regUse && quiet == 3'h4
    |-> carryOutRouted == sum[ctl.width]) else $error("final carry wrong");
  cascade_eq_a:
    assert property (ctl.mode == lccc_pkg::MODE_CMP && ctl.cascUse && quiet == 3'h4
    |-> cascadeOut == (((opA ^ opB) & msk) == 32'h0)) else $error("cascade compare wrong");
  dev_clear_a:
    assert property (!deviceWideResetN ##1 (!deviceWideResetN && ctl.devRstEn && ctl.out0Reg
    && !ctl.presetEmu && !ctl.simulEmu) |=> cellOut0 == 30'h0) else $error("reset left data");
  dev_preset_a:
    assert property (!deviceWideResetN ##1 (!deviceWideResetN && ctl.devRstEn && ctl.out0Reg
    && ctl.presetEmu) |=> (cellOut0 & msk[29:0]) == msk[29:0]) else $error("preset not set");
endmodule
bind lccc_cell_array lccc_array_chk u_chk (
  .clk, .sys_rst, .deviceWideResetN, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .cellOut0, .cellOut1, .carryOutRouted, .cascadeOut
);
`default_nettype wire

// [verif/lccc_fabric_model.sv]
/*
  neighbouring fabric that owns the device-wide reset pin.
  assumes pulseReq is held for one clock by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module lccc_fabric_model (
  input  wire logic clk,
  input  wire logic pulseReq,
  output var logic  deviceWideResetN
);
  initial deviceWideResetN = 1'b1;
  // pin moves on the edge like any input; the clear inside acts at once
  always @(posedge clk) begin
    if (pulseReq) begin
      deviceWideResetN <= 1'b0;
      repeat (3) @(posedge clk);
      deviceWideResetN <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verif/lccc_cell_array_tb_top.sv]
/*
  self-checking bench for the cell array with an inline arithmetic model.
  assumes the checker binds itself and the fabric model drives the reset pin.
*/
`timescale 1ns/1ns
`default_nettype none
module lccc_cell_array_tb_top;
  logic                 clk;
  logic                 sys_rst;
  logic                 pulseReq;
  wire logic            deviceWideResetN;
  logic [7:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [29:0]          cellOut0;
  logic [29:0]          cellOut1;
  logic                 carryOutRouted;
  logic                 cascadeOut;
  logic [31:0]          rd, a, b, lv, m, e;
  lccc_pkg::lccc_ctrl_t c;
  int                   failures, tests_run, cyc, k;
  time                  tDone, t1;
  lccc_cell_array dut (.clk, .sys_rst, .deviceWideResetN, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cellOut0, .cellOut1, .carryOutRouted,
    .cascadeOut);
  lccc_fabric_model fab (.clk, .pulseReq, .deviceWideResetN);
  // ------
  // tasks
  // ------
  // one access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    tDone = $time;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wctl;
    bus(1'b1, lccc_pkg::OFF_CTRL, {11'h000, c});
  endtask
  task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] mk,
                    input logic [31:0] ex);
    bus(1'b0, ad, 32'h0);
    tests_run++;
    if ((ex & mk) !== (rd & mk)) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, ex & mk, rd & mk);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // clock and hang guard; the run needs well under 5000 cycles
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pulseReq = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    k = $urandom(46);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rc("ctrl reset", lccc_pkg::OFF_CTRL, 32'h1FFFFF, 32'h080020);
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    rc("unmapped", 8'h24, 32'hFFFFFFFF, 32'h0);
    c = '0;
    c.width = 5'h08;
    c.grpClr = 3'h7;
    wctl();
    c.grpClr = 3'h0;
    wctl();
    rc("group clear", lccc_pkg::OFF_REGVAL, 32'hFF, 32'h0);
    // adders at both chain ends, the long one hopping groups
    for (int i = 0; i < 4; i++) begin
      a = $urandom();
      b = $urandom();
      c = '0;
      c.width = i[0] ? 5'h1D : 5'h08;
      c.carryIn0 = 1'($urandom_range(1, 0));
      c.simulEmu = i[1];
      m = (32'h1 << c.width) - 32'h1;
      e = (a & m) + (b & m) + {31'h0, c.carryIn0};
      k = c.width + 1 + (c.simulEmu ? 3 : 0);
      bus(1'b1, lccc_pkg::OFF_OPA, a);
      bus(1'b1, lccc_pkg::OFF_OPB, b);
      wctl();
      bus(1'b1, lccc_pkg::OFF_TABLE, ~e);
      rc("sum", lccc_pkg::OFF_TABLE, m, e);
      rc("final carry", lccc_pkg::OFF_STATUS, 32'h1, e >> c.width);
      rc("cells used", lccc_pkg::OFF_STATUS, 32'h3F00, 32'(k) << 8);
      rc("out0 table", lccc_pkg::OFF_OUT0, m, e);
    end
    // accumulator: edges counted between the two control writes
    b = $urandom_range(255, 1);
    c = '0;
    c.width = 5'h08;
    c.grpClr = 3'h7;
    c.regUse = 1'b1;
    c.out1Reg = 1'b1;
    wctl();
    bus(1'b1, lccc_pkg::OFF_OPB, b);
    c.grpClr = 3'h0;
    c.run = 1'b1;
    wctl();
    t1 = tDone;
    c.run = 1'b0;
    wctl();
    k = int'((tDone - t1) / 4);
    rc("accumulate", lccc_pkg::OFF_REGVAL, 32'hFF, 32'(k) * b);
    rc("out1 register", lccc_pkg::OFF_OUT1, 32'hFF, 32'(k) * b);
    // counter: load, count up, then clear and load against cascade
    lv = $urandom();
    bus(1'b1, lccc_pkg::OFF_LOADVAL, lv);
    c = '0;
    c.mode = lccc_pkg::MODE_COUNT;
    c.width = 5'h08;
    c.carryIn0 = 1'b1;
    c.run = 1'b1;
    c.sload = 1'b1;
    wctl();
    c.sload = 1'b0;
    wctl();
    t1 = tDone;
    c.run = 1'b0;
    wctl();
    k = int'((tDone - t1) / 4);
    rc("count", lccc_pkg::OFF_REGVAL, 32'hFF, lv + 32'(k));
    c.run = 1'b1;
    c.sload = 1'b1;
    c.sclr = 1'b1;
    c.cascUse = 1'b1;
    wctl();
    c.run = 1'b0;
    wctl();
    rc("clear wins", lccc_pkg::OFF_REGVAL, 32'hFF, 32'h0);
    c.run = 1'b1;
    c.sclr = 1'b0;
    wctl();
    c.run = 1'b0;
    wctl();
    rc("load over cascade", lccc_pkg::OFF_REGVAL, 32'hFF, lv);
    // wide compare over the cascade, equal then one bit apart
    a = $urandom();
    c = '0;
    c.mode = lccc_pkg::MODE_CMP;
    c.width = 5'h10;
    c.cascUse = 1'b1;
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? a : a ^ (32'h1 << $urandom_range(15, 0));
      bus(1'b1, lccc_pkg::OFF_OPA, a);
      bus(1'b1, lccc_pkg::OFF_OPB, b);
      wctl();
      rc("cascade", lccc_pkg::OFF_STATUS, 32'h2, {30'h0, i == 0, 1'b0});
    end
    // device reset: plain, preset, undefined, disabled
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.mode = lccc_pkg::MODE_COUNT;
      c.width = 5'h08;
      c.out0Reg = 1'b1;
      c.run = 1'b1;
      c.sload = 1'b1;
      c.devRstEn = (i != 3);
      c.presetEmu = (i == 1);
      c.simulEmu = (i == 2);
      wctl();
      c.run = 1'b0;
      wctl();
      bus(1'b1, lccc_pkg::OFF_STATUS, 32'h8);
      @(posedge clk);
      pulseReq <= 1'b1;
      @(posedge clk);
      pulseReq <= 1'b0;
      if (i != 2) begin
        rc("device reset", lccc_pkg::OFF_REGVAL, 32'hFF,
           (i == 3) ? lv : ((i == 1) ? 32'hFF : 32'h0));
      end
      if (i < 3) begin
        rc("reset flags", lccc_pkg::OFF_STATUS, 32'hC, (i == 2) ? 32'hC : 32'h8);
      end
    end
    // clearing group 2 alone must hit chain positions 10 to 19 only
    bus(1'b1, lccc_pkg::OFF_LOADVAL, 32'h3FFFFFFF);
    c = '0;
    c.mode = lccc_pkg::MODE_COUNT;
    c.width = 5'h1D;
    c.run = 1'b1;
    c.sload = 1'b1;
    wctl();
    c.run = 1'b0;
    c.grpClr = 3'h4;
    wctl();
    rc("group hop", lccc_pkg::OFF_REGVAL, 32'h1FFFFFFF, 32'h1FF003FF);
    end_sim();
  end
endmodule
`default_nettype wire
